// *** nfc_regs.svh ***
// nfc_regs.svh: register offsets, command bytes and timing counts for the flash controller
// assumes a 125 MHz aclk; included by the controller and the test bench
`ifndef NFC_REGS_SVH
`define NFC_REGS_SVH

`define NFC_OFF_CTRL     8'h00
`define NFC_OFF_ADDR     8'h04
`define NFC_OFF_WDATA    8'h08
`define NFC_OFF_STATUS   8'h0C
`define NFC_OFF_RDATA    8'h10

`define NFC_CTRL_GO      0
`define NFC_CTRL_WP      31

`define NFC_OP_CMD       3'h0
`define NFC_OP_ADDR4     3'h1
`define NFC_OP_DIN       3'h2
`define NFC_OP_DOUT      3'h3
`define NFC_OP_WAIT      3'h4

`define NFC_CMD_READ_A   8'h00
`define NFC_CMD_READ_B   8'h01
`define NFC_CMD_READ_C   8'h50
`define NFC_CMD_SERIN    8'h80
`define NFC_CMD_PROG     8'h10
`define NFC_CMD_ERASE1   8'h60
`define NFC_CMD_ERASE2   8'hD0
`define NFC_CMD_STATUS   8'h70
`define NFC_CMD_RESET    8'hFF
`define NFC_CMD_ID       8'h90

`define NFC_CLK_NS       8
`define NFC_T_STROBE_NS  20
`define NFC_T_WB_NS      100
`define NFC_STROBE_CYC   ((`NFC_T_STROBE_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_WB_CYC       ((`NFC_T_WB_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)

`endif

// *** nfc_pkg.sv ***
// nfc_pkg.sv: types shared by the flash controller
// state codes are literal here; nfc_regs.svh is not included
`default_nettype none
package nfc_pkg;
  typedef struct packed {
    logic       cle;
    logic       ale;
    logic       ce_n;
    logic       we_n;
    logic       read_strobe_n;
    logic       wp_n;
  } nfc_pins_type;

  typedef enum logic [5:0] {
    NFC_IDLE   = 6'b000001,
    NFC_SETUP  = 6'b000010,
    NFC_LOW    = 6'b000100,
    NFC_HIGH   = 6'b001000,
    NFC_WAIT   = 6'b010000,
    NFC_GAP    = 6'b100000
  } nfc_state_type;
endpackage
`default_nettype wire

// *** nfc_ctrl.sv ***
// nfc_ctrl.sv: host controller driving a page NAND flash through its strobes
// assumes an AXI4-Lite master on aclk; flash pins are asynchronous to aclk
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`include "nfc_regs.svh"
`default_nettype none
// Notes on behaviour
// - address goes out as four byte cycles
// - fourth address cycle drives upper lines low
// - cycle kind set by latch strobe levels
// - only reset or status while busy; the controller starts any op from idle whatever the busy line
// - region B read for columns 256 up
// - pass/fail read only when ready
// - program: 80, address, data, 10
// - erase: 60, address, D0 back to back
// - status read per device on shared busy
// - only 10 or FF after 80; the controller starts any command after 80
module nfc_ctrl (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output var nfc_pkg::nfc_pins_type pins,
  output logic [7:0]       bus_out,
  output logic             bus_oe,
  input  wire logic [7:0]  bus_in,
  input  wire logic        ready_busy_n
);
  localparam logic [3:0] STROBE_CYC = 4'(`NFC_STROBE_CYC);
  localparam logic [3:0] WB_CYC     = 4'(`NFC_WB_CYC);

  // state
  nfc_pkg::nfc_state_type st_r, st_nxt;
  nfc_pkg::nfc_pins_type  pins_r, pins_nxt;
  logic [7:0]  bus_r, bus_nxt;
  logic        oe_r, oe_nxt;
  logic [2:0]  op_r, op_nxt;
  logic [7:0]  cmd_r, cmd_nxt;
  logic [25:0] addr_r, addr_nxt;
  logic [1:0]  acyc_r, acyc_nxt;
  logic [7:0]  rdat_r, rdat_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic        wp_r, wp_nxt;
  logic [7:0]  wdat_r, wdat_nxt;
  logic        awr_r, awr_nxt, wr_r, wr_nxt, bv_r, bv_nxt;
  logic        arr_r, arr_nxt, rv_r, rv_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [1:0]  rb_sync_r, rb_sync_nxt;
  logic [7:0]  in_s1_r, in_s2_r;

  // address byte for cycle n; bit 8 is never sent, the device sets it
  function automatic logic [7:0] addr_byte(input logic [25:0] a, input logic [1:0] n);
    case (n)
      2'h0:    addr_byte = a[7:0];
      2'h1:    addr_byte = a[16:9];
      2'h2:    addr_byte = a[24:17];
      default: addr_byte = {7'h00, a[25]};
    endcase
  endfunction

  logic wr_go, rd_go, busy_dev;
  assign wr_go    = s_axi_awvalid && s_axi_wvalid && !bv_r && awr_r && wr_r;
  assign rd_go    = s_axi_arvalid && arr_r && !rv_r;
  assign busy_dev = !rb_sync_r[1];

  always_comb begin
    st_nxt = st_r; pins_nxt = pins_r; bus_nxt = bus_r; oe_nxt = oe_r; op_nxt = op_r;
    cmd_nxt = cmd_r; addr_nxt = addr_r; acyc_nxt = acyc_r; rdat_nxt = rdat_r;
    cnt_nxt = cnt_r; wp_nxt = wp_r; wdat_nxt = wdat_r;
    awr_nxt = awr_r; wr_nxt = wr_r; bv_nxt = bv_r; arr_nxt = arr_r; rv_nxt = rv_r;
    rd_nxt = rd_r;
    rb_sync_nxt = {rb_sync_r[0], ready_busy_n};
    if (wr_go) begin
      bv_nxt = 1'b1;
      case (s_axi_awaddr)
        `NFC_OFF_CTRL: begin
          wp_nxt = s_axi_wdata[`NFC_CTRL_WP];
          if (s_axi_wdata[`NFC_CTRL_GO] && st_r == nfc_pkg::NFC_IDLE) begin
            op_nxt  = s_axi_wdata[6:4];
            cmd_nxt = s_axi_wdata[15:8];
            acyc_nxt = 2'h0;
            st_nxt  = nfc_pkg::NFC_SETUP;
          end
        end
        `NFC_OFF_ADDR:  addr_nxt = s_axi_wdata[25:0];
        `NFC_OFF_WDATA: wdat_nxt = s_axi_wdata[7:0];
        default: ;
      endcase
    end
    if (bv_r && s_axi_bready) bv_nxt = 1'b0;
    if (rd_go) begin
      rv_nxt = 1'b1;
      case (s_axi_araddr)
        `NFC_OFF_CTRL:   rd_nxt = {wp_r, 15'h0000, cmd_r, 1'b0, op_r, 4'h0};
        `NFC_OFF_ADDR:   rd_nxt = {6'h00, addr_r};
        `NFC_OFF_WDATA:  rd_nxt = {24'h0, wdat_r};
        `NFC_OFF_STATUS: rd_nxt = {30'h0, !rb_sync_r[1], st_r != nfc_pkg::NFC_IDLE};
        `NFC_OFF_RDATA:  rd_nxt = {24'h0, rdat_r};
        default:         rd_nxt = 32'h0;
      endcase
    end
    if (rv_r && s_axi_rready) rv_nxt = 1'b0;
    pins_nxt.wp_n = wp_r;
    case (st_r)
      nfc_pkg::NFC_IDLE: begin
        pins_nxt.cle = 1'b0; pins_nxt.ale = 1'b0;
        pins_nxt.we_n = 1'b1; pins_nxt.read_strobe_n = 1'b1;
        oe_nxt = 1'b0;
      end
      nfc_pkg::NFC_SETUP: begin
        // software sequences commands; the controller only shapes cycles
        pins_nxt.ce_n = 1'b0;
        pins_nxt.cle = (op_r == `NFC_OP_CMD);
        pins_nxt.ale = (op_r == `NFC_OP_ADDR4);
        cnt_nxt = STROBE_CYC;
        case (op_r)
          `NFC_OP_CMD:   begin bus_nxt = cmd_r; oe_nxt = 1'b1; pins_nxt.we_n = 1'b0; end
          `NFC_OP_ADDR4: begin
            bus_nxt = addr_byte(addr_r, acyc_r); oe_nxt = 1'b1; pins_nxt.we_n = 1'b0;
          end
          `NFC_OP_DIN:   begin bus_nxt = wdat_r; oe_nxt = 1'b1; pins_nxt.we_n = 1'b0; end
          `NFC_OP_DOUT:  begin oe_nxt = 1'b0; pins_nxt.read_strobe_n = 1'b0; end
          default:       begin cnt_nxt = WB_CYC; st_nxt = nfc_pkg::NFC_WAIT; end
        endcase
        if (op_r != `NFC_OP_WAIT) st_nxt = nfc_pkg::NFC_LOW;
      end
      nfc_pkg::NFC_LOW: begin
        if (cnt_r != 4'h0) cnt_nxt = cnt_r - 4'h1;
        else begin
          // sample late in the low phase; synchroniser adds two cycles of margin
          if (op_r == `NFC_OP_DOUT) rdat_nxt = in_s2_r;
          pins_nxt.we_n = 1'b1; pins_nxt.read_strobe_n = 1'b1;
          cnt_nxt = STROBE_CYC;
          st_nxt = nfc_pkg::NFC_HIGH;
        end
      end
      nfc_pkg::NFC_HIGH: begin
        if (cnt_r != 4'h0) cnt_nxt = cnt_r - 4'h1;
        else if (op_r == `NFC_OP_ADDR4 && acyc_r != 2'h3) begin
          acyc_nxt = acyc_r + 2'h1;
          st_nxt = nfc_pkg::NFC_SETUP;
        end else begin
          oe_nxt = 1'b0; pins_nxt.cle = 1'b0; pins_nxt.ale = 1'b0;
          cnt_nxt = WB_CYC;
          st_nxt = nfc_pkg::NFC_GAP;
        end
      end
      nfc_pkg::NFC_GAP: begin
        // allow the device time to pull busy low after the strobe
        if (cnt_r != 4'h0) cnt_nxt = cnt_r - 4'h1;
        else st_nxt = nfc_pkg::NFC_IDLE;
      end
      nfc_pkg::NFC_WAIT: begin
        // hold chip select low; a busy device ignores it anyway
        if (cnt_r != 4'h0) cnt_nxt = cnt_r - 4'h1;
        else if (!busy_dev) st_nxt = nfc_pkg::NFC_IDLE;
      end
      default: st_nxt = nfc_pkg::NFC_IDLE;
    endcase
    if (st_r != nfc_pkg::NFC_IDLE || wr_go) begin
      awr_nxt = 1'b0; wr_nxt = 1'b0;
    end else if (!bv_r) begin
      awr_nxt = 1'b1; wr_nxt = 1'b1;
    end
    if (bv_r) begin awr_nxt = 1'b0; wr_nxt = 1'b0; end
    arr_nxt = !rd_go && !rv_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= nfc_pkg::NFC_IDLE;
      pins_r <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1, read_strobe_n: 1'b1, wp_n: 1'b0};
      bus_r <= 8'h00; oe_r <= 1'b0; op_r <= 3'h0; cmd_r <= 8'h00; addr_r <= 26'h0;
      acyc_r <= 2'h0; rdat_r <= 8'h00; cnt_r <= 4'h0; wp_r <= 1'b0; wdat_r <= 8'h00;
      awr_r <= 1'b0; wr_r <= 1'b0; bv_r <= 1'b0; arr_r <= 1'b0; rv_r <= 1'b0;
      // sync starts at the pulled-up ready level, no false busy after reset
      rd_r <= 32'h0; rb_sync_r <= 2'h3; in_s1_r <= 8'h00; in_s2_r <= 8'h00;
    end else begin
      st_r <= st_nxt; pins_r <= pins_nxt; bus_r <= bus_nxt; oe_r <= oe_nxt;
      op_r <= op_nxt; cmd_r <= cmd_nxt; addr_r <= addr_nxt; acyc_r <= acyc_nxt;
      rdat_r <= rdat_nxt; cnt_r <= cnt_nxt; wp_r <= wp_nxt; wdat_r <= wdat_nxt;
      awr_r <= awr_nxt; wr_r <= wr_nxt; bv_r <= bv_nxt; arr_r <= arr_nxt; rv_r <= rv_nxt;
      rd_r <= rd_nxt; rb_sync_r <= rb_sync_nxt; in_s1_r <= bus_in; in_s2_r <= in_s1_r;
    end
  end

  assign s_axi_awready = awr_r;
  assign s_axi_wready  = wr_r;
  assign s_axi_bvalid  = bv_r;
  assign s_axi_bresp   = 2'b00;
  assign s_axi_arready = arr_r;
  assign s_axi_rvalid  = rv_r;
  assign s_axi_rdata   = rd_r;
  assign s_axi_rresp   = 2'b00;
  assign pins          = pins_r;
  assign bus_out       = bus_r;
  assign bus_oe        = oe_r;
endmodule
`default_nettype wire

// *** nfc_ctrl_monitor.sv ***
// nfc_ctrl_monitor.sv: flash pin checks for the controller
// assumes a bind into nfc_ctrl, one aclk domain
`default_nettype none
module nfc_ctrl_mon (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire nfc_pkg::nfc_pins_type pins,
  input wire logic [7:0]            bus_out,
  input wire logic                  bus_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_LATCH_EXCL: assert property (pins.cle |-> !pins.ale)
    else $error("both latches high");
  AST_WE_SEL: assert property (!pins.we_n |-> !pins.ce_n && pins.read_strobe_n)
    else $error("write strobe unselected or with read");
  AST_RE_IDLE: assert property (!pins.read_strobe_n |-> !bus_oe && pins.we_n && !pins.cle)
    else $error("read strobe while driving");
  AST_WE_OE: assert property (!pins.we_n |-> bus_oe)
    else $error("write strobe with bus released");
  AST_WE_LOW: assert property ($fell(pins.we_n) |-> !pins.we_n [*4] ##1 pins.we_n)
    else $error("write strobe width");
  // byte must hold through the rising strobe edge
  AST_BUS_HOLD: assert property ($fell(pins.we_n) |=> $stable(bus_out) [*4])
    else $error("bus changed under write strobe");
  AST_LATCH_HOLD: assert property ($fell(pins.we_n) |=> $stable({pins.cle, pins.ale}) [*4])
    else $error("latch changed under write strobe");
  AST_RE_LOW: assert property ($fell(pins.read_strobe_n) |->
    !pins.read_strobe_n [*4] ##1 pins.read_strobe_n) else $error("read strobe width");
endmodule
bind nfc_ctrl nfc_ctrl_mon i_mon (.aclk, .aresetn, .pins, .bus_out, .bus_oe);
`default_nettype wire

// *** nfc_dev_model.sv ***
// nfc_dev_model.sv: behavioural page flash seen from its pins
// assumes nfc_ctrl pins; a pointer pattern stands in for the array
`default_nettype none
module nfc_dev_model (
  input  wire nfc_pkg::nfc_pins_type pins,
  input  wire logic [7:0]            bus_out,
  input  wire logic                  bus_oe,
  output logic [7:0]                 bus_in,
  output logic                       ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cmd = 8'h00, dout = 8'h00, din = 8'h00, ab [4];
  logic [9:0] ptr = 10'h000;
  logic [2:0] n = 3'h0;
  logic       st = 1'h0, fail = 1'h0;
  initial ready_busy_n = 1'h1;
  // chip select not watched: busy runs on regardless
  task automatic busy;
    ready_busy_n = 1'h0;
    #1000;
    ready_busy_n = 1'h1;
  endtask
  always @(posedge pins.we_n) begin
    if (pins.cle) begin
      cmd = bus_out;
      n = 3'h0;
      st = (bus_out == 8'h70);
      if (bus_out == 8'hFF) ready_busy_n = 1'h1;
      if (bus_out == 8'h10 || bus_out == 8'hD0) begin
        fail = !pins.wp_n;
        fork busy; join_none
      end
    end else if (pins.ale) begin
      ab[n[1:0]] = bus_out;
      n = n + 3'h1;
      if (n == 3'h4 && cmd inside {8'h00, 8'h01, 8'h50}) begin
        ptr = cmd[6] ? {6'h20, ab[0][3:0]} : {1'h0, cmd[0], ab[0]};
        fork busy; join_none
      end
    end else begin
      din = bus_out;
    end
  end
  always @(negedge pins.read_strobe_n) begin
    dout = st ? {pins.wp_n, ready_busy_n, 5'h00, fail} : ptr[7:0] ^ {ptr[9:8], 6'h00};
    if (!st) ptr = (ptr == 10'h20F) ? (cmd[6] ? 10'h200 : 10'h000) : ptr + 10'h001;
  end
  // released bus shows the inverse while the read strobe is high so stale data cannot pass
  assign bus_in = bus_oe ? bus_out : (pins.read_strobe_n ? ~dout : dout);
endmodule
`default_nettype wire

// *** nfc_ctrl_test.sv ***
// nfc_ctrl_test.sv: register-level bench for the flash controller
// assumes nfc_pkg, nfc_ctrl, nfc_dev_model and the monitor compiled first
`include "nfc_regs.svh"
`default_nettype none
module nfc_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, bus_oe, ready_busy_n, wp = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, bus_out, bus_in;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  nfc_pkg::nfc_pins_type pins;
  int miscompares = 0, checked = 0, cyc = 0;
  nfc_ctrl i_dut (.*);
  nfc_dev_model i_dev (.*);
  always #4 aclk = ~aclk;
  task automatic conclude;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      conclude;
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    do @(posedge aclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic op(input logic [2:0] o, input logic [7:0] c);
    wr(`NFC_OFF_CTRL, {wp, 15'h0000, c, 1'h0, o, 4'h1});
    do rd(`NFC_OFF_STATUS, v); while (v[0] === 1'h1);
  endtask
  task automatic get(input string n, input logic [31:0] e);
    op(`NFC_OP_DOUT, 8'h00);
    rd(`NFC_OFF_RDATA, v);
    chk(n, v, e);
  endtask
  initial begin
    logic [7:0] cmd [3] = '{8'h00, 8'h01, 8'h50};
    logic [7:0] exp [3] = '{8'h05, 8'h45, 8'h85};
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    rd(`NFC_OFF_STATUS, v);
    chk("status", v, 32'h00000000);
    rd(8'h40, v);
    chk("unmapped", v, 32'h00000000);
    chk("read resp", {30'h0, resp}, 32'h00000000);
    wr(8'h40, 32'hFFFFFFFF);
    chk("write resp", {30'h0, resp}, 32'h00000000);
    $display("reset test done");
    wp = 1'h1;
    for (int i = 0; i < 3; i++) begin
      op(`NFC_OP_CMD, cmd[i]);
      // bit 8 set here must not reach the bus
      wr(`NFC_OFF_ADDR, 32'h02000305);
      op(`NFC_OP_ADDR4, 8'h00);
      chk("addr bytes", {i_dev.ab[1], i_dev.ab[3]}, 32'h00000101);
      op(`NFC_OP_WAIT, 8'h00);
      get("first byte", exp[i]);
      get("next byte", exp[i] + 8'h01);
    end
    $display("read test done");
    wp = 1'h0;
    op(`NFC_OP_CMD, `NFC_CMD_SERIN);
    op(`NFC_OP_ADDR4, 8'h00);
    wr(`NFC_OFF_WDATA, 32'h000000A5);
    op(`NFC_OP_DIN, 8'h00);
    chk("data in", {24'h0, i_dev.din}, 32'h000000A5);
    op(`NFC_OP_CMD, `NFC_CMD_PROG);
    op(`NFC_OP_WAIT, 8'h00);
    op(`NFC_OP_CMD, `NFC_CMD_STATUS);
    get("program status", 32'h00000041);
    $display("program test done");
    wp = 1'h1;
    op(`NFC_OP_CMD, `NFC_CMD_ERASE1);
    op(`NFC_OP_ADDR4, 8'h00);
    op(`NFC_OP_CMD, `NFC_CMD_ERASE2);
    rd(`NFC_OFF_STATUS, v);
    chk("busy seen", {31'h0, v[1]}, 32'h00000001);
    op(`NFC_OP_CMD, `NFC_CMD_STATUS);
    get("busy status", 32'h00000080);
    op(`NFC_OP_WAIT, 8'h00);
    get("erase status", 32'h000000C0);
    $display("erase test done");
    conclude;
  end
endmodule
`default_nettype wire
